// >>> core/indexer_pkg.sv
/*
  Shared constants, types and decode helpers of the microstep indexer.
  Assumes a single 10 MHz clock and tri-level pins already resolved to codes.
*/
// What this block does
// - High mode select high with low select open or high gives 32 microsteps, rising only or both edges.
// - Mode pin pairs map to full, half, quarter, eighth, sixteenth, thirty-second step rates.
// - Both mode selects are read as low, open or high.
// - A changed mode takes effect at the next step, landing on a valid position.
// - Position returns home at 45 degrees after reset, lockout exit, sleep exit.
// - Each qualifying step edge moves exactly one position of the current spacing.
// - Direction high walks angle upward; low walks it downward.
// - Positive current drives the positive terminal high; negative reverses it.
// - 128-entry cosine/sine cycle; coarse modes skip entries, full uses diagonals.
// - Reaching the chop threshold puts that bridge into decay for the off-time.
// - When the off-time ends the bridge drives again, starting a new cycle.
// - Off-time select: low 20 us, open 10 us, high 30 us.
// - Threshold is reference times torque times table value, divided by 6.6.
// - Torque selects scale both windings from 100 down to 0 percent, in eighths.
// - Output disable high turns off only the bridges; indexing carries on.
package indexer_pkg;
  typedef enum logic [1:0] {TRI_LOW = 2'h0, TRI_OPEN = 2'h1, TRI_HIGH = 2'h2} tri_level_e;
  typedef enum logic [2:0] {MODE_FULL = 3'h0, MODE_HALF = 3'h1, MODE_QUARTER = 3'h2,
    MODE_EIGHTH = 3'h3, MODE_SIXTEENTH = 3'h4, MODE_THIRTYSECOND = 3'h5} step_mode_e;
  localparam int         TRI_STATES = 3;
  localparam int         CODE_COUNT = 9;
  localparam step_mode_e MODE_BY_CODE [CODE_COUNT] = '{MODE_FULL, MODE_HALF, MODE_QUARTER,
    MODE_EIGHTH, MODE_EIGHTH, MODE_SIXTEENTH, MODE_SIXTEENTH, MODE_THIRTYSECOND,
    MODE_THIRTYSECOND};
  localparam logic       BOTH_EDGES_BY_CODE [CODE_COUNT] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
    1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic [3:0] TORQUE_EIGHTHS [CODE_COUNT] = '{4'h8, 4'h7, 4'h6, 4'h5, 4'h4,
    4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [3:0] TORQUE_NONE = 4'h0;
  localparam logic [6:0] STEP_SIZE [6] = '{7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
  localparam logic [6:0] HOME_POS = 7'h10;
  localparam logic [6:0] FULL_OFFSET = 7'h10;
  localparam logic [6:0] QUARTER_POS = 7'h20;
  localparam logic [6:0] WITHIN_QUARTER = 7'h1f;
  localparam logic [5:0] QUARTER_LAST = 6'h20;
  localparam logic [6:0] QUARTER_COS [33] = '{7'h64, 7'h64, 7'h64, 7'h63, 7'h62, 7'h61,
    7'h60, 7'h5e, 7'h5c, 7'h5a, 7'h58, 7'h56, 7'h53, 7'h50, 7'h4d, 7'h4a, 7'h47, 7'h43,
    7'h3f, 7'h3c, 7'h38, 7'h33, 7'h2f, 7'h2b, 7'h26, 7'h22, 7'h1d, 7'h18, 7'h14, 7'h0f,
    7'h0a, 7'h05, 7'h00};
  localparam int         CLK_HZ = 10_000_000;
  localparam int         US_PER_S = 1_000_000;
  localparam int         OFF_LOW_US = 20;
  localparam int         OFF_OPEN_US = 10;
  localparam int         OFF_HIGH_US = 30;
  localparam logic [8:0] OFF_LOW_CYC = 9'(OFF_LOW_US * (CLK_HZ / US_PER_S));
  localparam logic [8:0] OFF_OPEN_CYC = 9'(OFF_OPEN_US * (CLK_HZ / US_PER_S));
  localparam logic [8:0] OFF_HIGH_CYC = 9'(OFF_HIGH_US * (CLK_HZ / US_PER_S));
  localparam int         VREF_BITS = 12;
  localparam logic [11:0] VREF_RESET = 12'h0ce4;
  localparam int         PCT_FULL = 100;
  localparam int         EIGHTHS_FULL = 8;
  localparam int         ATTEN_TENTHS = 66;
  localparam int         TENTHS = 10;
  localparam int         THRESH_DIV = PCT_FULL * EIGHTHS_FULL * ATTEN_TENTHS;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] VREF_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] CURRENT_OFS = 8'h0c;
  localparam logic [7:0] THRESH_OFS = 8'h10;
  localparam int         CTRL_SLEEP_BIT = 0;
  localparam logic       CTRL_SLEEP_RESET = 1'b0;
  localparam int         HTRANS_ACTIVE_BIT = 1;
  typedef struct packed {
    logic [15:0] reserved;
    logic [1:0]  decay;
    logic [1:0]  bridge_on;
    logic        lockout;
    step_mode_e  mode;
    logic        both_edges;
    logic [6:0]  position;
  } status_s;
  function automatic logic [3:0] tri_index(logic [1:0] v);
    return (v == TRI_LOW) ? 4'h0 : (v == TRI_OPEN) ? 4'h1 : 4'h2;
  endfunction : tri_index
  function automatic logic [3:0] select_code(logic [1:0] hi, logic [1:0] lo);
    return 4'(tri_index(hi) * TRI_STATES + tri_index(lo));
  endfunction : select_code
endpackage : indexer_pkg

// >>> core/chop_if.sv
/*
  Carrier between the indexer top and one winding's off-time timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface chop_if;
  logic       run;
  logic       tripped;
  logic [8:0] off_cycles;
  logic       decay;
  modport unit (input run, input tripped, input off_cycles, output decay);
  modport ctl  (output run, output tripped, output off_cycles, input decay);
endinterface : chop_if

// >>> core/chop_timer.sv
/*
  Fixed off-time PWM timer for one bridge.
  Assumes run and tripped are synchronous to clk_in.
*/
`timescale 1ns/1ns
module chop_timer
  import indexer_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  chop_if.unit     ch
);
  typedef enum logic [1:0] {CH_IDLE = 2'h0, CH_DRIVE = 2'h1, CH_DECAY = 2'h3} chop_state_e;
  chop_state_e state, next_state;
  logic [8:0]  count, next_count, dwell, held_off;

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      CH_IDLE: if (ch.run) next_state = CH_DRIVE;
      CH_DRIVE: begin
        if (!ch.run) begin
          next_state = CH_IDLE;
        end else if (ch.tripped) begin
          next_state = CH_DECAY;
          next_count = ch.off_cycles;
        end
      end
      CH_DECAY: begin
        if (!ch.run) next_state = CH_IDLE;
        else if (count <= 9'h001) next_state = CH_DRIVE;
        else next_count = count - 9'h001;
      end
      default: next_state = CH_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state    <= CH_IDLE;
      count    <= '0;
      dwell    <= '0;
      held_off <= '0;
    end else begin
      state    <= next_state;
      count    <= next_count;
      dwell    <= (state == CH_DECAY) ? dwell + 9'h001 : '0;
      held_off <= (state != CH_DECAY) ? ch.off_cycles : held_off;
    end
  end
  assign ch.decay = (state == CH_DECAY);

  property p_trip;
    @(posedge clk_in) disable iff (rst_in)
    (state == CH_DRIVE && ch.run && ch.tripped) |=> ch.decay;
  endproperty
  a_trip: assert property (p_trip) else $error("trip did not start decay");
  property p_off_len;
    @(posedge clk_in) disable iff (rst_in)
    (state == CH_DRIVE && $past(state) == CH_DECAY) |-> dwell == held_off;
  endproperty
  a_off_len: assert property (p_off_len) else $error("off-time length wrong");
endmodule : chop_timer

// >>> core/winding_current_lookup.sv
/*
  Signed winding current percentages for an indexer position.
  Assumes a 7-bit position over one electrical cycle.
*/
`timescale 1ns/1ns
module winding_current_lookup
  import indexer_pkg::*;
(
  input  wire logic [6:0]  position_in,
  output logic signed [7:0] current_a_out,
  output logic signed [7:0] current_b_out
);
  // Quarter wave mirrored and negated per quadrant
  function automatic logic signed [7:0] cos_pct(logic [6:0] angle);
    logic [5:0] r;
    logic [7:0] mag;
    r = {1'b0, angle[4:0]};
    if (angle[5]) r = QUARTER_LAST - r;
    mag = {1'b0, QUARTER_COS[r]};
    return (angle[6] ^ angle[5]) ? -mag : mag;
  endfunction : cos_pct

  // cosine for A, sine for B
  assign current_a_out = cos_pct(position_in);
  assign current_b_out = cos_pct(position_in - QUARTER_POS);
endmodule : winding_current_lookup

// >>> core/microstep_indexer_current_control.sv
/*
  Step/direction microstep indexer with fixed off-time chopping control.
  Assumes pins synchronous to clk_in, tri-level pins given as low/open/high
  codes, and an AHB-Lite master with a single slave.
*/
`timescale 1ns/1ns
module microstep_indexer_current_control
  import indexer_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic              hsel_in,
  input  wire logic              hready_in,
  input  wire logic [31:0]       hwdata_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  input  wire logic              step_in,
  input  wire logic              direction_in,
  input  wire logic [1:0]        microstep_select_high_in,
  input  wire logic [1:0]        microstep_select_low_in,
  input  wire logic [1:0]        torque_select_high_in,
  input  wire logic [1:0]        torque_select_low_in,
  input  wire logic [1:0]        off_time_choice_in,
  input  wire logic              output_stage_disable_n_in,
  input  wire logic              supply_lockout_in,
  input  wire logic [1:0][11:0]  sense_resistor_node_in,
  output logic      [1:0]        winding_terminal_pos_out,
  output logic      [1:0]        winding_terminal_neg_out,
  output logic      [1:0]        bridge_on_out
);
  // ------------------------------------------------------------------
  // Pin decode
  // ------------------------------------------------------------------
  logic [3:0] mode_code;
  logic [3:0] torque_code;
  step_mode_e mode;
  logic       both_edges;
  logic [3:0] torque;
  logic [8:0] off_cycles;
  logic [6:0] step_size;
  logic [6:0] offset;

  always_comb begin
    mode_code   = select_code(microstep_select_high_in, microstep_select_low_in);
    torque_code = select_code(torque_select_high_in, torque_select_low_in);
    mode        = MODE_BY_CODE[mode_code];
    both_edges  = BOTH_EDGES_BY_CODE[mode_code];
    torque      = TORQUE_EIGHTHS[torque_code];
    step_size   = STEP_SIZE[mode];
    offset      = (mode == MODE_FULL) ? FULL_OFFSET : '0;
    case (off_time_choice_in)
      TRI_LOW:  off_cycles = OFF_LOW_CYC;
      TRI_OPEN: off_cycles = OFF_OPEN_CYC;
      default:  off_cycles = OFF_HIGH_CYC;
    endcase
  end

  // ------------------------------------------------------------------
  // Indexer
  // ------------------------------------------------------------------
  logic       step_prev;
  logic       next_step_prev;
  logic [6:0] position;
  logic [6:0] next_position;
  logic       sleep;
  logic       idle;
  logic       rise;
  logic       fall;
  logic       qualify;
  logic [6:0] rel;
  logic [6:0] base;
  logic       aligned;

  always_comb begin
    next_step_prev = step_in;
    idle    = sleep || supply_lockout_in;
    rise    = step_in && !step_prev;
    fall    = !step_in && step_prev;
    // falling edge only in both-edge modes
    qualify = rise || (fall && both_edges);
    rel     = position - offset;
    base    = rel & ~(step_size - 7'h01);
    aligned = (rel == base);
    next_position = position;
    // held home while asleep or locked out
    if (idle) begin
      next_position = HOME_POS;
    end else if (qualify) begin
      // one position, direction, realign to new mode
      if (direction_in) next_position = base + step_size + offset;
      else if (aligned) next_position = base - step_size + offset;
      else next_position = base + offset;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      step_prev <= 1'b0;
      position  <= HOME_POS;
    end else begin
      step_prev <= next_step_prev;
      position  <= next_position;
    end
  end

  // ------------------------------------------------------------------
  // Current regulation
  // ------------------------------------------------------------------
  logic signed [7:0] cur [2];
  logic [1:0][11:0]  thr;
  logic [1:0]        decay;
  logic              drive_allowed;
  logic [11:0]       vref;
  logic [1:0]        next_pos;
  logic [1:0]        next_neg;
  logic [1:0]        next_on;
  chop_if            chop [2] ();

  winding_current_lookup u_lookup (
    .position_in   (position),
    .current_a_out (cur[0]),
    .current_b_out (cur[1])
  );

  // bridges off, indexer keeps running; zero torque also off
  assign drive_allowed = !idle && !output_stage_disable_n_in && (torque != TORQUE_NONE);

  for (genvar g = 0; g < 2; g++) begin : g_winding
    logic [7:0]  mag;
    logic [31:0] product;
    assign mag     = cur[g][7] ? 8'(-cur[g]) : 8'(cur[g]);
    // reference times torque times table, over 6.6
    assign product = 32'(vref) * 32'(torque) * 32'(mag) * 32'(TENTHS);
    assign thr[g]  = 12'(product / 32'(THRESH_DIV));
    assign chop[g].run        = drive_allowed;
    assign chop[g].tripped    = sense_resistor_node_in[g] >= thr[g];
    assign chop[g].off_cycles = off_cycles;
    assign decay[g]           = chop[g].decay;
    chop_timer u_chop (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ch     (chop[g])
    );
    // polarity follows current sign; decay pulls both low
    assign next_on[g]  = drive_allowed;
    assign next_pos[g] = drive_allowed && !decay[g] && (cur[g] > 8'sh00);
    assign next_neg[g] = drive_allowed && !decay[g] && (cur[g] < 8'sh00);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      winding_terminal_pos_out <= '0;
      winding_terminal_neg_out <= '0;
      bridge_on_out            <= '0;
    end else begin
      winding_terminal_pos_out <= next_pos;
      winding_terminal_neg_out <= next_neg;
      bridge_on_out            <= next_on;
    end
  end

  // ------------------------------------------------------------------
  // AHB-Lite register slave
  // ------------------------------------------------------------------
  // Read data is prepared in the address phase, so reads see a write that
  // is still in its data phase through the next_ values.
  logic        wr_pend;
  logic        next_wr_pend;
  logic [7:0]  wr_addr;
  logic [7:0]  next_wr_addr;
  logic        next_sleep;
  logic [11:0] next_vref;
  logic [31:0] next_hrdata;
  logic        bus_take;
  status_s     status;

  always_comb begin
    bus_take   = hsel_in && htrans_in[HTRANS_ACTIVE_BIT] && hready_in;
    next_sleep = sleep;
    next_vref  = vref;
    if (wr_pend) begin
      case (wr_addr)
        CTRL_OFS: next_sleep = hwdata_in[CTRL_SLEEP_BIT];
        VREF_OFS: next_vref  = hwdata_in[VREF_BITS-1:0];
        default:  next_sleep = sleep;
      endcase
    end
    next_wr_pend = bus_take && hwrite_in;
    next_wr_addr = bus_take ? haddr_in[7:0] : wr_addr;
    status = '0;
    status.decay      = decay;
    status.bridge_on  = bridge_on_out;
    status.lockout    = supply_lockout_in;
    status.mode       = mode;
    status.both_edges = both_edges;
    status.position   = position;
    next_hrdata = '0;
    if (bus_take && !hwrite_in) begin
      case (haddr_in[7:0])
        CTRL_OFS:    next_hrdata = 32'(next_sleep);
        VREF_OFS:    next_hrdata = 32'(next_vref);
        STATUS_OFS:  next_hrdata = status;
        CURRENT_OFS: next_hrdata = {16'h0000, cur[1], cur[0]};
        THRESH_OFS:  next_hrdata = {16'(thr[1]), 16'(thr[0])};
        default:     next_hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend       <= 1'b0;
      wr_addr       <= '0;
      sleep         <= CTRL_SLEEP_RESET;
      vref          <= VREF_RESET;
      hrdata_out    <= '0;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend       <= next_wr_pend;
      wr_addr       <= next_wr_addr;
      sleep         <= next_sleep;
      vref          <= next_vref;
      hrdata_out    <= next_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_step_up;
    @(posedge clk_in) disable iff (rst_in)
    (qualify && !idle && direction_in && aligned) |=>
      position == $past(position) + $past(step_size);
  endproperty
  a_step_up: assert property (p_step_up) else $error("upward step size wrong");

  property p_step_down;
    @(posedge clk_in) disable iff (rst_in)
    (qualify && !idle && !direction_in && aligned) |=>
      position == $past(position) - $past(step_size);
  endproperty
  a_step_down: assert property (p_step_down) else $error("downward step wrong");

  property p_fall_ignored;
    @(posedge clk_in) disable iff (rst_in)
    (fall && !both_edges && !idle) |=> $stable(position);
  endproperty
  a_fall_ignored: assert property (p_fall_ignored) else $error("falling edge moved");

  property p_home;
    @(posedge clk_in) disable iff (rst_in)
    idle |=> position == HOME_POS;
  endproperty
  a_home: assert property (p_home) else $error("indexer not at home");

  property p_full_diag;
    @(posedge clk_in) disable iff (rst_in)
    (!idle && qualify && mode == MODE_FULL) |=> (position & WITHIN_QUARTER) == FULL_OFFSET;
  endproperty
  a_full_diag: assert property (p_full_diag) else $error("full step off diagonal");

  property p_polarity;
    @(posedge clk_in) disable iff (rst_in)
    (drive_allowed && !decay[0] && cur[0] > 8'sh00) |=>
      winding_terminal_pos_out[0] && !winding_terminal_neg_out[0];
  endproperty
  a_polarity: assert property (p_polarity) else $error("bridge polarity wrong");

  property p_disable;
    @(posedge clk_in) disable iff (rst_in)
    output_stage_disable_n_in |=> bridge_on_out == 2'b00 ##1 bridge_on_out == 2'b00
      || !$past(output_stage_disable_n_in);
  endproperty
  a_disable: assert property (p_disable) else $error("bridges on while disabled");

  property p_torque_off;
    @(posedge clk_in) disable iff (rst_in)
    (torque_code == 4'h8) |=> bridge_on_out == 2'b00 && winding_terminal_pos_out == 2'b00;
  endproperty
  a_torque_off: assert property (p_torque_off) else $error("zero torque drives");

  property p_off_sel;
    @(posedge clk_in) disable iff (rst_in)
    (off_time_choice_in == TRI_OPEN) |-> chop[0].off_cycles == OFF_OPEN_CYC;
  endproperty
  a_off_sel: assert property (p_off_sel) else $error("open select not 10 us");
endmodule : microstep_indexer_current_control

// >>> tb/motion_controller_model.sv
/*
  Motion controller model: one step pulse per request, direction set first.
  Assumes go_in is raised for one request at a time, synchronous to clk_in.
*/
`timescale 1ns/1ns
module motion_controller_model #(
  parameter int HALF = 20
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic go_in,
  input  wire logic dir_in,
  output logic      step_out,
  output logic      direction_out,
  output logic      busy_out
);
  logic [7:0] count;
  logic [1:0] phase;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      step_out      <= 1'b0;
      direction_out <= 1'b1;
      busy_out      <= 1'b0;
      count         <= 8'h00;
      phase         <= 2'h0;
    end else if (!busy_out) begin
      busy_out      <= go_in;
      direction_out <= go_in ? dir_in : direction_out;
      count         <= 8'h00;
      phase         <= 2'h0;
    end else if (count == 8'(HALF - 1)) begin
      // setup, high and low each a half period
      count    <= 8'h00;
      phase    <= phase + 2'h1;
      step_out <= (phase == 2'h2) ? step_out : ~step_out;
      busy_out <= (phase != 2'h2);
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule : motion_controller_model

// >>> tb/microstep_indexer_current_control_tb.sv
/*
  Bench of the indexer: a table of step-mode rows, then hand tests.
  Assumes zero wait-state AHB-Lite answers and a 10 MHz clock.
*/
`timescale 1ns/1ns
module microstep_indexer_current_control_tb
  import indexer_pkg::*;
;
  typedef struct packed {
    tri_level_e hi;
    tri_level_e lo;
    logic       up;
    logic [6:0] pos;
    step_mode_e mode;
    logic       both;
    logic [7:0] ca;
    logic [7:0] cb;
  } row_s;
  localparam row_s ROWS [9] = '{
    '{TRI_LOW, TRI_LOW, 1'b0, 7'h70, MODE_FULL, 1'b0, 8'h47, 8'hb9},
    '{TRI_LOW, TRI_OPEN, 1'b0, 7'h00, MODE_HALF, 1'b0, 8'h64, 8'h00},
    '{TRI_LOW, TRI_HIGH, 1'b1, 7'h18, MODE_QUARTER, 1'b0, 8'h26, 8'h5c},
    '{TRI_OPEN, TRI_LOW, 1'b0, 7'h0c, MODE_EIGHTH, 1'b0, 8'h53, 8'h38},
    '{TRI_OPEN, TRI_OPEN, 1'b1, 7'h18, MODE_EIGHTH, 1'b1, 8'h26, 8'h5c},
    '{TRI_OPEN, TRI_HIGH, 1'b0, 7'h0e, MODE_SIXTEENTH, 1'b0, 8'h4d, 8'h3f},
    '{TRI_HIGH, TRI_LOW, 1'b1, 7'h14, MODE_SIXTEENTH, 1'b1, 8'h38, 8'h53},
    '{TRI_HIGH, TRI_OPEN, 1'b0, 7'h0f, MODE_THIRTYSECOND, 1'b0, 8'h4a, 8'h43},
    '{TRI_HIGH, TRI_HIGH, 1'b1, 7'h12, MODE_THIRTYSECOND, 1'b1, 8'h3f, 8'h4d}};
  logic             clk_in, rst_in, hwrite, hsel, go, go_dir, step, dir, dis_n, lockout;
  logic             busy, hready, hresp;
  logic [1:0]       htrans, pos, neg, bon;
  logic [1:0]       ms_hi, ms_lo, tq_hi, tq_lo, off_sel;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0][11:0] sense;
  logic [8:0]       offx [3];
  int               n_fail, comparisons, cycles, n;
  wire              decay_a = bon[0] & ~pos[0] & ~neg[0];

  microstep_indexer_current_control dut (
    .clk_in                    (clk_in),
    .rst_in                    (rst_in),
    .haddr_in                  (haddr),
    .htrans_in                 (htrans),
    .hwrite_in                 (hwrite),
    .hsize_in                  (3'h2),
    .hsel_in                   (hsel),
    .hready_in                 (hready),
    .hwdata_in                 (hwdata),
    .hrdata_out                (hrdata),
    .hreadyout_out             (hready),
    .hresp_out                 (hresp),
    .step_in                   (step),
    .direction_in              (dir),
    .microstep_select_high_in  (ms_hi),
    .microstep_select_low_in   (ms_lo),
    .torque_select_high_in     (tq_hi),
    .torque_select_low_in      (tq_lo),
    .off_time_choice_in        (off_sel),
    .output_stage_disable_n_in (dis_n),
    .supply_lockout_in         (lockout),
    .sense_resistor_node_in    (sense),
    .winding_terminal_pos_out  (pos),
    .winding_terminal_neg_out  (neg),
    .bridge_on_out             (bon)
  );
  motion_controller_model ctl (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .go_in         (go),
    .dir_in        (go_dir),
    .step_out      (step),
    .direction_out (dir),
    .busy_out      (busy)
  );

  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Ceiling well above the ~1700 cycles of the whole run
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_in);
      cycles++;
      if (cycles == 60000) begin
        n_fail++;
        $display("wrong value at %0t: run hung", $time);
        conclude();
      end
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_word
  task automatic wait_ready();
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
  endtask : wait_ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr  <= 32'(a);
    hwrite <= wr;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb
  task automatic check_pos(input logic [6:0] p, input string what);
    ahb(1'b0, STATUS_OFS, 32'h0000_0000);
    check_word(32'({hresp, rd[6:0]}), 32'(p), what);
  endtask : check_pos
  // Sleep entry and exit brings the indexer home
  task automatic go_home();
    ahb(1'b1, CTRL_OFS, 32'h0000_0001);
    ahb(1'b1, CTRL_OFS, 32'h0000_0000);
  endtask : go_home
  task automatic pulse(input logic up);
    go     <= 1'b1;
    go_dir <= up;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    while (busy !== 1'b0) @(posedge clk_in);
    @(posedge clk_in);
  endtask : pulse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_in, hwrite, hsel, go, go_dir, dis_n, lockout} = 7'b1000000;
    {ms_hi, ms_lo, tq_hi, tq_lo, off_sel} = '0;
    {htrans, haddr, hwdata, sense} = '0;
    offx = '{OFF_LOW_CYC, OFF_OPEN_CYC, OFF_HIGH_CYC};
    n_fail = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_in);
    check_word(32'({hready, hresp, bon, pos, neg}), 32'h0000_0080, "reset pins");
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    check_pos(HOME_POS, "home after reset");
    ahb(1'b0, CURRENT_OFS, 32'h0000_0000);
    check_word(rd, 32'h0000_4747, "home current");
    ahb(1'b0, VREF_OFS, 32'h0000_0000);
    check_word(rd, 32'h0000_0ce4, "vref reset");
    ahb(1'b0, 8'h14, 32'h0000_0000);
    check_word(rd, 32'h0000_0000, "unmapped");
    $display("test reset done");
    foreach (ROWS[i]) begin
      go_home();
      ms_hi <= ROWS[i].hi;
      ms_lo <= ROWS[i].lo;
      pulse(ROWS[i].up);
      ahb(1'b0, STATUS_OFS, 32'h0000_0000);
      check_word(32'(rd[10:0]), {21'h0, ROWS[i].mode, ROWS[i].both, ROWS[i].pos}, "step");
      ahb(1'b0, CURRENT_OFS, 32'h0000_0000);
      check_word(rd, {16'h0, ROWS[i].cb, ROWS[i].ca}, "current");
      check_word(32'({pos, neg, bon}), {26'h0, ~ROWS[i].cb[7] & |ROWS[i].cb,
        ~ROWS[i].ca[7] & |ROWS[i].ca, ROWS[i].cb[7], ROWS[i].ca[7], 2'h3}, "terminals");
      $display("test row %0d done", i);
    end
    go_home();
    {ms_hi, ms_lo} <= {TRI_OPEN, TRI_LOW};
    pulse(1'b1);
    {ms_hi, ms_lo} <= {TRI_LOW, TRI_HIGH};
    pulse(1'b1);
    check_pos(7'h18, "mode change up");
    {ms_hi, ms_lo} <= {TRI_LOW, TRI_LOW};
    pulse(1'b0);
    check_pos(7'h10, "mode change down");
    $display("test mode change done");
    for (int c = 0; c < 9; c++) begin
      tq_hi <= tri_level_e'(2'(c / 3));
      tq_lo <= tri_level_e'(2'(c % 3));
      repeat (2) @(posedge clk_in);
      n = (3300 * (8 - c) * 710) / 52800;
      ahb(1'b0, THRESH_OFS, 32'h0000_0000);
      check_word(rd, {4'h0, 12'(n), 4'h0, 12'(n)}, "threshold");
      check_word(32'(bon), (c == 8) ? 32'h0000_0000 : 32'h0000_0003, "torque off");
    end
    {tq_hi, tq_lo} <= {TRI_LOW, TRI_LOW};
    ahb(1'b1, VREF_OFS, 32'h0000_0672);
    ahb(1'b0, THRESH_OFS, 32'h0000_0000);
    check_word(32'(rd[11:0]), 32'h0000_00b1, "half vref");
    ahb(1'b1, VREF_OFS, 32'h0000_0ce4);
    $display("test torque done");
    for (int k = 0; k < 3; k++) begin
      off_sel <= tri_level_e'(2'(k));
      @(posedge clk_in);
      sense[0] <= 12'h0fff;
      @(posedge clk_in);
      while (decay_a !== 1'b1) @(posedge clk_in);
      sense[0] <= 12'h0000;
      n = 1;
      @(posedge clk_in);
      while (decay_a === 1'b1) begin
        n++;
        @(posedge clk_in);
      end
      check_word(32'(n), 32'(offx[k]), "off time");
      check_word(32'({pos, neg}), 32'h0000_000c, "drive again");
    end
    $display("test chop done");
    dis_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    check_word(32'({bon, pos, neg}), 32'h0000_0000, "disabled");
    pulse(1'b1);
    check_pos(7'h30, "step while disabled");
    dis_n   <= 1'b0;
    lockout <= 1'b1;
    pulse(1'b1);
    ahb(1'b0, STATUS_OFS, 32'h0000_0000);
    check_word(32'({rd[11], rd[6:0]}), 32'h0000_0090, "lockout home");
    check_word(32'(bon), 32'h0000_0000, "lockout off");
    lockout <= 1'b0;
    pulse(1'b0);
    check_pos(7'h70, "after lockout");
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    check_pos(HOME_POS, "second reset");
    $display("test disable and lockout done");
    conclude();
  end
endmodule : microstep_indexer_current_control_tb
